/* axis_sup_pkg.sv */
package axis_sup_pkg;

	// =====================================================
	// register byte offsets
	localparam logic [5:0] OFS_CTRL     = 6'h00;
	localparam logic [5:0] OFS_FALLBACK = 6'h04;
	localparam logic [5:0] OFS_MANUAL_A = 6'h08;
	localparam logic [5:0] OFS_MANUAL_B = 6'h0c;
	localparam logic [5:0] OFS_SPD_LIM  = 6'h10;
	localparam logic [5:0] OFS_WINDOW   = 6'h14;
	localparam logic [5:0] OFS_TEST_LO  = 6'h18;
	localparam logic [5:0] OFS_TEST_HI  = 6'h1c;
	localparam logic [5:0] OFS_TEST_PER = 6'h20;
	localparam logic [5:0] OFS_STATUS   = 6'h24;

	// =====================================================
	// control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EXPERT   = 2;
	localparam int CTRL_REMOTE   = 3;
	localparam int CTRL_DEFAULTS = 4;

	// =====================================================
	// status register fields
	localparam int STAT_READY    = 0;
	localparam int STAT_IN_POS   = 1;
	localparam int STAT_LATCHED  = 2;
	localparam int STAT_PRESENT  = 3;
	localparam int STAT_MANUAL   = 4;
	localparam int STAT_OUT_EN   = 5;

	typedef enum logic [1:0] {
		MON_OFF  = 2'h0,
		MON_ON   = 2'h1,
		MON_AUTO = 2'h2
	} mon_mode_t;

	// =====================================================
	// reset values
	localparam logic [1:0]         RST_MODE     = 2'h1;
	localparam logic signed [15:0] RST_FALLBACK = 16'sh0000;
	localparam logic signed [15:0] RST_MANUAL_A = 16'sh0d02;
	localparam logic signed [15:0] RST_MANUAL_B = -16'sh0d02;
	localparam logic [15:0]        RST_SPD_LIM  = 16'h2710;
	localparam logic [17:0]        RST_WINDOW   = 18'h000c8;
	localparam logic [13:0]        RST_TEST_LO  = 14'h0019;
	localparam logic [13:0]        RST_TEST_HI  = 14'h004b;
	localparam logic [15:0]        RST_TEST_PER = 16'h0000;

	// =====================================================
	// limits and timing
	localparam logic [15:0] LEVEL_MAX    = 16'h2710;
	localparam logic [17:0] WINDOW_MIN   = 18'h00002;
	localparam logic [17:0] WINDOW_MAX   = 18'h30d40;
	localparam int          UM_PER_MM    = 1000;
	localparam int          CLK_HZ       = 40000000;
	localparam int          PROC_CYCLE_US = 1000;
	localparam int          PROC_CYCLES  = CLK_HZ / 1000000 * PROC_CYCLE_US;

endpackage

/* proc_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module proc_tick #(
	parameter int CYCLES = 40000
) (
	input  wire logic i_clk,
	input  wire logic i_nrst,
	output logic      o_tick
);
	logic [31:0] cnt_r;

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_r  <= 32'h0;
			o_tick <= 1'b0;
		end
		else if (cnt_r == 32'(CYCLES - 1))
		begin
			cnt_r  <= 32'h0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_r  <= cnt_r + 32'h1;
			o_tick <= 1'b0;
		end
	end
endmodule // proc_tick
`default_nettype wire

/* test_square_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module test_square_gen (
	input  wire logic        i_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_tick,
	input  wire logic        i_enable,
	input  wire logic [15:0] i_period_ms,
	output logic             o_upper
);
	logic [15:0] ms_r;

	// toggles between lower and upper each time the cycle time elapses
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ms_r    <= 16'h0;
			o_upper <= 1'b0;
		end
		else if (!i_enable || i_period_ms == 16'h0)
		begin
			ms_r    <= 16'h0;
			o_upper <= 1'b0;
		end
		else if (i_tick)
		begin
			if (ms_r >= i_period_ms - 16'h1)
			begin
				ms_r    <= 16'h0;
				o_upper <= ~o_upper;
			end
			else
				ms_r <= ms_r + 16'h1;
		end
	end
endmodule // test_square_gen
`default_nettype wire

/* axis_supervision.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// [RQ1] mode on: monitor all, clear on enable low
// [RQ2] mode off: no monitoring, no failure flagged
// [RQ3] mode auto: failure clears once condition gone
// [RQ4] monitor loop sensor, current, range, internal
// [RQ5] failure shows as ready deasserted
// [RQ6] not ready drives programmed fallback level
// [RQ7] zero fallback switches output stage off
// [RQ8] operator uses one for centre current
// [RQ9] fallback kept apart from parameter defaults
// [RQ10] manual input drives signed manual speed
// [RQ11] manual release holds current position
// [RQ12] sensor fault: manual allowed, release switches off; code: mode on blocks manual once latched, release gives fallback level
// [RQ13] manual speed limited by active speed limit
// [RQ14] fallback used after manual release
// [RQ15] in-position when error below window
// [RQ16] in-position flag does not affect control
// [RQ17] in-position only while start active
// [RQ18] standard view hides expert commands
// [RQ19] remote mode square wave between positions
// [RQ20] ready needs enable and no failure
module axis_supervision
	import axis_sup_pkg::*;
#(
	parameter int TICK_CYCLES = axis_sup_pkg::PROC_CYCLES
) (
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic [5:0]         i_address,
	input  wire logic               i_read,
	input  wire logic               i_write,
	input  wire logic [31:0]        i_writedata,
	output logic [31:0]             o_readdata,
	output logic                    o_waitrequest,
	input  wire logic               i_enable,
	input  wire logic               i_start,
	input  wire logic               i_manual_a,
	input  wire logic               i_manual_b,
	input  wire logic               i_ext_speed_sel,
	input  wire logic [15:0]        i_ext_speed,
	input  wire logic signed [31:0] i_cmd_pos,
	input  wire logic signed [31:0] i_act_pos,
	input  wire logic signed [15:0] i_ctrl_level,
	input  wire logic               i_flt_loop_sensor,
	input  wire logic               i_flt_pos_sensor,
	input  wire logic               i_flt_out_current,
	input  wire logic               i_flt_range,
	input  wire logic               i_flt_internal,
	output logic                    o_ready,
	output logic                    o_in_position,
	output logic signed [15:0]      o_out_level,
	output logic                    o_out_enable,
	output logic                    o_hold_valid,
	output logic signed [31:0]      o_hold_pos,
	output logic                    o_test_active,
	output logic signed [31:0]      o_test_demand
);
	// =====================================================
	// helpers
	function automatic logic [31:0] abs32(input logic signed [31:0] v);
		return v[31] ? 32'(-v) : 32'(v);
	endfunction

	function automatic logic [15:0] abs16(input logic signed [15:0] v);
		return v[15] ? 16'(-v) : 16'(v);
	endfunction

	// =====================================================
	// registers
	mon_mode_t          mode_r;
	logic               expert_r;
	logic               remote_r;
	logic signed [15:0] fallback_r;
	logic signed [15:0] man_a_r;
	logic signed [15:0] man_b_r;
	logic [15:0]        spd_lim_r;
	logic [17:0]        window_r;
	logic [13:0]        test_lo_r;
	logic [13:0]        test_hi_r;
	logic [15:0]        test_per_r;
	logic               latched_r;
	logic               manual_r;

	logic        tick;
	logic        test_upper;
	logic        wr_acc;
	logic        rd_acc;
	logic        present;
	logic        manual;
	logic        ready_nxt;
	logic [15:0] speed_lim;
	logic [15:0] man_mag;
	logic [15:0] man_lim;
	logic [31:0] pos_err;

	assign wr_acc = i_write && !o_waitrequest;
	assign rd_acc = i_read && o_waitrequest;
	assign manual = i_manual_a || i_manual_b;
	assign pos_err = abs32(i_cmd_pos - i_act_pos);

	// =====================================================
	// divider and test generator
	proc_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.o_tick (tick)
	);

	test_square_gen u_square (
		.i_clk       (i_clk),
		.i_nrst      (i_nrst),
		.i_tick      (tick),
		.i_enable    (remote_r),
		.i_period_ms (test_per_r),
		.o_upper     (test_upper)
	);

	// =====================================================
	// bus handshake: one wait state, answer in second cycle
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_waitrequest <= 1'b1;
		else
			o_waitrequest <= !((i_read || i_write) && o_waitrequest);
	end

	// =====================================================
	// control register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			mode_r   <= mon_mode_t'(RST_MODE);
			expert_r <= 1'b0;
			remote_r <= 1'b0;
		end
		else if (wr_acc && i_address == OFS_CTRL)
		begin
			case (i_writedata[CTRL_MODE_LSB +: 2])
				MON_OFF:  mode_r <= MON_OFF;
				MON_AUTO: mode_r <= MON_AUTO;
				default:  mode_r <= MON_ON;
			endcase
			expert_r <= i_writedata[CTRL_EXPERT];
			remote_r <= i_writedata[CTRL_REMOTE];
		end
	end

	// =====================================================
	// fallback level: expert only, untouched by restore
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			fallback_r <= RST_FALLBACK;
		else if (wr_acc && expert_r && i_address == OFS_FALLBACK
			&& abs16(i_writedata[15:0]) <= LEVEL_MAX)     // [RQ9] [RQ18]
			fallback_r <= i_writedata[15:0];
	end

	// =====================================================
	// parameter set with restore-defaults command
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			man_a_r    <= RST_MANUAL_A;
			man_b_r    <= RST_MANUAL_B;
			spd_lim_r  <= RST_SPD_LIM;
			window_r   <= RST_WINDOW;
			test_lo_r  <= RST_TEST_LO;
			test_hi_r  <= RST_TEST_HI;
			test_per_r <= RST_TEST_PER;
		end
		else if (wr_acc && i_address == OFS_CTRL
			&& i_writedata[CTRL_DEFAULTS])
		begin
			man_a_r    <= RST_MANUAL_A;                   // [RQ9]
			man_b_r    <= RST_MANUAL_B;
			spd_lim_r  <= RST_SPD_LIM;
			window_r   <= RST_WINDOW;
			test_lo_r  <= RST_TEST_LO;
			test_hi_r  <= RST_TEST_HI;
			test_per_r <= RST_TEST_PER;
		end
		else if (wr_acc)
		begin
			case (i_address)
				OFS_MANUAL_A:
					if (abs16(i_writedata[15:0]) <= LEVEL_MAX) // [RQ10]
						man_a_r <= i_writedata[15:0];
				OFS_MANUAL_B:
					if (abs16(i_writedata[15:0]) <= LEVEL_MAX)
						man_b_r <= i_writedata[15:0];
				OFS_SPD_LIM:
					if (i_writedata[15:0] != 16'h0
						&& i_writedata[15:0] <= LEVEL_MAX)
						spd_lim_r <= i_writedata[15:0];
				OFS_WINDOW:
					if (i_writedata[17:0] >= WINDOW_MIN
						&& i_writedata[17:0] <= WINDOW_MAX
						&& i_writedata[31:18] == 14'h0)   // [RQ15]
						window_r <= i_writedata[17:0];
				OFS_TEST_LO:  test_lo_r  <= i_writedata[13:0];
				OFS_TEST_HI:  test_hi_r  <= i_writedata[13:0];
				OFS_TEST_PER: test_per_r <= i_writedata[15:0];
				default:      ;
			endcase
		end
	end

	// =====================================================
	// read data
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_readdata <= 32'h0;
		else if (rd_acc)
		begin
			case (i_address)
				OFS_CTRL:
					o_readdata <= {28'h0, remote_r, expert_r, mode_r};
				OFS_FALLBACK:                                 // [RQ18]
					o_readdata <= expert_r ? 32'(fallback_r) : 32'h0;
				OFS_MANUAL_A: o_readdata <= 32'(man_a_r);
				OFS_MANUAL_B: o_readdata <= 32'(man_b_r);
				OFS_SPD_LIM:  o_readdata <= {16'h0, spd_lim_r};
				OFS_WINDOW:   o_readdata <= {14'h0, window_r};
				OFS_TEST_LO:  o_readdata <= {18'h0, test_lo_r};
				OFS_TEST_HI:  o_readdata <= {18'h0, test_hi_r};
				OFS_TEST_PER: o_readdata <= {16'h0, test_per_r};
				OFS_STATUS:
					o_readdata <= {26'h0, o_out_enable, manual_r,
						present, latched_r, o_in_position, o_ready};
				default:      o_readdata <= 32'h0;
			endcase
		end
	end

	// =====================================================
	// supervision
	always_comb
	begin
		present = (mode_r != MON_OFF)                         // [RQ2]
			&& (i_flt_loop_sensor || i_flt_pos_sensor      // [RQ4]
			|| i_flt_out_current || i_flt_range || i_flt_internal);
		ready_nxt = i_enable && !present                      // [RQ20]
			&& !(latched_r && mode_r == MON_ON);          // [RQ3]
	end

	// a new failure wins over the clear by enable low
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			latched_r <= 1'b0;
		else if (mode_r == MON_ON && present)
			latched_r <= 1'b1;                            // [RQ1]
		else if (!i_enable || mode_r != MON_ON)
			latched_r <= 1'b0;                            // [RQ1]
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_ready <= 1'b0;
		else
			o_ready <= ready_nxt;                         // [RQ5]
	end

	// =====================================================
	// output level selection
	always_comb
	begin
		speed_lim = i_ext_speed_sel ? i_ext_speed : spd_lim_r;
		man_mag   = i_manual_a ? abs16(man_a_r) : abs16(man_b_r);
		man_lim   = (man_mag < speed_lim) ? man_mag : speed_lim; // [RQ13]
	end

	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_out_level  <= 16'sh0;
			o_out_enable <= 1'b0;
		end
		else if (manual && i_enable && (ready_nxt
			|| (i_flt_pos_sensor && !latched_r)))         // [RQ12]
		begin
			o_out_enable <= 1'b1;                         // [RQ10]
			if ((i_manual_a ? man_a_r[15] : man_b_r[15]))
				o_out_level <= 16'(-$signed({1'b0, man_lim[14:0]}));
			else
				o_out_level <= $signed(man_lim);
		end
		else if (!ready_nxt)
		begin
			o_out_level  <= fallback_r;                   // [RQ6] [RQ14]
			o_out_enable <= (fallback_r != 16'sh0);       // [RQ7] [RQ12]
		end
		else
		begin
			o_out_level  <= i_ctrl_level;
			o_out_enable <= 1'b1;
		end
	end

	// =====================================================
	// position hold after manual release
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			manual_r     <= 1'b0;
			o_hold_valid <= 1'b0;
			o_hold_pos   <= 32'sh0;
		end
		else
		begin
			manual_r <= manual;
			if (manual_r && !manual && ready_nxt)
			begin
				o_hold_valid <= 1'b1;                     // [RQ11]
				o_hold_pos   <= i_act_pos;
			end
			else if (manual || i_start || !ready_nxt)
				o_hold_valid <= 1'b0;
		end
	end

	// =====================================================
	// in-position flag, status only
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_in_position <= 1'b0;
		else                                              // [RQ16]
			o_in_position <= i_start                      // [RQ17]
				&& (pos_err < 32'(window_r));             // [RQ15]
	end

	// =====================================================
	// commissioning square-wave demand
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_test_active <= 1'b0;
			o_test_demand <= 32'sh0;
		end
		else
		begin
			o_test_active <= remote_r;                    // [RQ19]
			o_test_demand <= 32'(test_upper ? test_hi_r : test_lo_r)
				* 32'(UM_PER_MM);                         // [RQ19]
		end
	end

endmodule // axis_supervision
`default_nettype wire

/* sensor_valve_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: position sensor with break injection and the valve stage
module sensor_valve_model (
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic               i_break,
	input  wire logic signed [31:0] i_pos,
	input  wire logic signed [15:0] i_level,
	input  wire logic               i_drive_en,
	output logic signed [31:0]      o_pos,
	output logic                    o_fault,
	output logic signed [15:0]      o_stage_level
);
	// =========================================================
	// sensor: a broken loop reports no usable position
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			o_pos <= '0;
		else if (i_break)
			o_pos <= ~o_pos;
		else
			o_pos <= i_pos;

	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			o_fault <= 1'b0;
		else
			o_fault <= i_break;

	// =========================================================
	// valve stage: no current while the stage is off
	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			o_stage_level <= '0;
		else
			o_stage_level <= i_drive_en ? i_level : '0;
endmodule // sensor_valve_model
`default_nettype wire

/* axis_supervision_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module axis_sup_asserts
	import axis_sup_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_nrst,
	input  wire logic [5:0]         i_address,
	input  wire logic               i_write,
	input  wire logic [31:0]        i_writedata,
	input  wire logic               o_waitrequest,
	input  wire logic               i_enable,
	input  wire logic               i_start,
	input  wire logic               i_manual_a,
	input  wire logic               i_manual_b,
	input  wire logic               i_ext_speed_sel,
	input  wire logic [15:0]        i_ext_speed,
	input  wire logic signed [31:0] i_cmd_pos,
	input  wire logic signed [31:0] i_act_pos,
	input  wire logic signed [15:0] i_ctrl_level,
	input  wire logic               i_flt_loop_sensor,
	input  wire logic               i_flt_pos_sensor,
	input  wire logic               i_flt_out_current,
	input  wire logic               i_flt_range,
	input  wire logic               i_flt_internal,
	input  wire logic               o_ready,
	input  wire logic               o_in_position,
	input  wire logic signed [15:0] o_out_level,
	input  wire logic               o_out_enable
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	// =========================================================
	// monitor mode as last written over the bus
	logic [1:0] mode_r;
	logic       flt;

	assign flt = i_flt_loop_sensor | i_flt_pos_sensor | i_flt_out_current
		| i_flt_range | i_flt_internal;

	always_ff @(posedge i_clk or negedge i_nrst)
		if (!i_nrst)
			mode_r <= RST_MODE;
		else if (i_write && !o_waitrequest && i_address == OFS_CTRL)
			mode_r <= (i_writedata[1:0] == 2'h3)
				? MON_ON : i_writedata[1:0];

	// =========================================================
	// assertions
	wait_pulse_a: assert property ($fell(o_waitrequest) |=> o_waitrequest)
		else $error("waitrequest low for more than one cycle");
	ready_en_a: assert property (o_ready |-> $past(i_enable))
		else $error("ready without enable");
	fault_ready_a: assert property (flt && mode_r != MON_OFF |=> !o_ready)
		else $error("failure did not drop ready");
	off_ready_a: assert property (mode_r == MON_OFF && i_enable |=> o_ready)
		else $error("failure flagged with monitoring off");
	latch_hold_a: assert property (mode_r == MON_ON && flt ##1
		(i_enable && mode_r == MON_ON)[*4] |-> !o_ready)
		else $error("latched failure cleared without enable low");
	auto_ok_a: assert property (mode_r == MON_AUTO && !flt && i_enable
		|=> o_ready) else $error("auto mode did not resume");
	in_position_flag_start_a: assert property (!i_start |=> !o_in_position)
		else $error("in-position without start");
	in_position_flag_eq_a: assert property (i_start && i_cmd_pos == i_act_pos
		|=> o_in_position) else $error("in-position missing at zero error");
	normal_out_a: assert property (o_ready && i_enable && !flt
		&& !i_manual_a && !i_manual_b
		|=> o_out_enable && o_out_level == $past(i_ctrl_level))
		else $error("control level not passed through");
	manual_lim_a: assert property ((i_manual_a || i_manual_b)
		&& i_ext_speed_sel
		&& o_ready && i_enable && !flt |=> o_out_enable
		&& (o_out_level < 0 ? -o_out_level : o_out_level)
		<= $past(i_ext_speed)) else $error("manual speed above limit");

	cover property (mode_r == MON_ON && flt ##1 i_enable[*4]);
	cover property (i_manual_a && o_out_enable);
	cover property ($rose(o_in_position));
endmodule // axis_sup_asserts

bind axis_supervision axis_sup_asserts chk_u (.i_clk, .i_nrst, .i_address,
	.i_write, .i_writedata, .o_waitrequest, .i_enable, .i_start, .i_manual_a,
	.i_manual_b, .i_ext_speed_sel, .i_ext_speed, .i_cmd_pos, .i_act_pos,
	.i_ctrl_level, .i_flt_loop_sensor, .i_flt_pos_sensor, .i_flt_out_current,
	.i_flt_range, .i_flt_internal, .o_ready, .o_in_position, .o_out_level,
	.o_out_enable);
`default_nettype wire

/* axis_supervision_manual_in_position_flag_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
	begin \
		num_checks++; \
		if ((a) !== (b)) \
		begin \
			err_total++; \
			$display("[FAIL] %0t mismatch %h vs %h", $time, a, b); \
		end \
	end
module axis_supervision_manual_in_position_flag_tb_top;
	import axis_sup_pkg::*;
	logic clk = 0, nrst = 0, rd_s = 0, wr_s = 0, en = 0, st = 0;
	logic ma = 0, mb = 0, xs = 0, brk = 0;
	logic [5:0] addr = '0;
	logic [31:0] wdat = '0, rdata;
	logic [15:0] xsp = '0;
	logic [3:0] flt = '0;
	logic signed [31:0] cmd = '0, pos = '0, m_pos, hpos, tdem;
	logic signed [15:0] lvl = 16'sh0100, olvl, stg;
	logic wreq, rdy, in_position_flag, oen, hv, tact, m_flt;
	int err_total = 0, num_checks = 0, cyc = 0, k;

	always #12.5 clk = ~clk;

	axis_supervision #(.TICK_CYCLES(4)) dut_u (.i_clk(clk), .i_nrst(nrst),
		.i_address(addr), .i_read(rd_s), .i_write(wr_s),
		.i_writedata(wdat), .o_readdata(rdata), .o_waitrequest(wreq),
		.i_enable(en), .i_start(st), .i_manual_a(ma), .i_manual_b(mb),
		.i_ext_speed_sel(xs), .i_ext_speed(xsp), .i_cmd_pos(cmd),
		.i_act_pos(m_pos), .i_ctrl_level(lvl), .i_flt_loop_sensor(flt[0]),
		.i_flt_pos_sensor(m_flt), .i_flt_out_current(flt[1]),
		.i_flt_range(flt[2]), .i_flt_internal(flt[3]), .o_ready(rdy),
		.o_in_position(in_position_flag), .o_out_level(olvl), .o_out_enable(oen),
		.o_hold_valid(hv), .o_hold_pos(hpos), .o_test_active(tact),
		.o_test_demand(tdem));

	sensor_valve_model far_u (.i_clk(clk), .i_nrst(nrst), .i_break(brk),
		.i_pos(pos), .i_level(olvl), .i_drive_en(oen), .o_pos(m_pos),
		.o_fault(m_flt), .o_stage_level(stg));

	// =========================================================
	// bus access, closing report and hang guard
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		addr <= a;
		wdat <= d;
		wr_s <= w;
		rd_s <= !w;
		do
			@(posedge clk);
		while (wreq !== 1'b0);
		q = rdata;
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, '0, q);
		`CHK(q, e)
	endtask

	task automatic wc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic ip(input logic signed [31:0] c, input logic e);
		cmd <= c;
		wc(3);
		`CHK(in_position_flag, e)
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			test_done;
		end
	end

	// =========================================================
	// scenarios
	initial
	begin
		wc(20);
		nrst <= 1'b1;
		wc(1);
		rc(OFS_CTRL, 32'h1);
		rc(OFS_MANUAL_A, 32'hd02);
		rc(OFS_MANUAL_B, 32'hfffff2fe);
		rc(OFS_SPD_LIM, 32'h2710);
		rc(OFS_WINDOW, 32'hc8);
		rc(OFS_TEST_LO, 32'h19);
		rc(OFS_TEST_HI, 32'h4b);
		rc(OFS_TEST_PER, 32'h0);
		rc(6'h3c, 32'h0);
		wr(OFS_FALLBACK, 32'h4d2);
		rc(OFS_FALLBACK, 32'h0);
		wr(OFS_CTRL, 32'h5);
		wr(OFS_FALLBACK, 32'hffffd8f0);
		wr(OFS_FALLBACK, 32'h2711);
		rc(OFS_FALLBACK, 32'hffffd8f0);
		wc(2);
		`CHK(olvl, 16'shd8f0);
		wr(OFS_FALLBACK, 32'h0);
		wc(3);
		`CHK(stg, 16'sh0000);
		`CHK(oen, 1'b0);
		wr(OFS_FALLBACK, 32'h1);
		wr(OFS_CTRL, 32'h11);
		wc(3);
		`CHK(olvl, 16'sh0001);
		rc(OFS_FALLBACK, 32'h0);
		en <= 1'b1;
		wc(3);
		`CHK(olvl, 16'sh0100);
		rc(OFS_STATUS, 32'h21);
		for (int i = 0; i < 4; i++)
		begin
			flt <= 4'h1 << i;
			wc(1);
			flt <= 4'h0;
			wc(4);
			`CHK(rdy, 1'b0);
			en <= 1'b0;
			wc(2);
			en <= 1'b1;
			wc(3);
			`CHK(rdy, 1'b1);
		end
		wr(OFS_CTRL, 32'h2);
		flt <= 4'h4;
		wc(3);
		`CHK(rdy, 1'b0);
		flt <= 4'h0;
		wc(3);
		`CHK(rdy, 1'b1);
		wr(OFS_CTRL, 32'h0);
		flt <= 4'hf;
		wc(3);
		`CHK(rdy, 1'b1);
		flt <= 4'h0;
		wr(OFS_CTRL, 32'h1);
		pos <= 32'sh1388;
		ma <= 1'b1;
		wc(3);
		`CHK(olvl, 16'sh0d02);
		ma <= 1'b0;
		mb <= 1'b1;
		wc(3);
		`CHK(olvl, 16'shf2fe);
		xs <= 1'b1;
		xsp <= 16'h03e8;
		wc(3);
		`CHK(olvl, 16'shfc18);
		xs <= 1'b0;
		wr(OFS_SPD_LIM, 32'h7d0);
		wc(3);
		`CHK(olvl, 16'shf830);
		mb <= 1'b0;
		wc(3);
		`CHK(hv, 1'b1);
		`CHK(hpos, 32'sh1388);
		`CHK(olvl, 16'sh0100);
		wr(OFS_CTRL, 32'h6);
		brk <= 1'b1;
		ma <= 1'b1;
		wc(3);
		`CHK(olvl, 16'sh07d0);
		ma <= 1'b0;
		wc(3);
		`CHK(olvl, 16'sh0001);
		wr(OFS_FALLBACK, 32'h0);
		wc(3);
		`CHK(oen, 1'b0);
		brk <= 1'b0;
		wr(OFS_CTRL, 32'h1);
		ip(32'sh1388, 1'b0);
		st <= 1'b1;
		ip(32'sh1388, 1'b1);
		`CHK(olvl, 16'sh0100);
		ip(32'sh144f, 1'b1);
		ip(32'sh1450, 1'b0);
		ip(32'sh12c0, 1'b0);
		wr(OFS_WINDOW, 32'h2);
		wr(OFS_WINDOW, 32'h1);
		rc(OFS_WINDOW, 32'h2);
		ip(32'sh1387, 1'b1);
		ip(32'sh138a, 1'b0);
		wr(OFS_TEST_PER, 32'h2);
		wr(OFS_CTRL, 32'h9);
		wc(3);
		`CHK(tact, 1'b1);
		for (k = 0; k < 100 && tdem !== 32'sh124f8; k++)
			@(posedge clk);
		for (k = 0; k < 100 && tdem !== 32'sh61a8; k++)
			@(posedge clk);
		`CHK(k, 8);
		wr(OFS_TEST_PER, 32'h0);
		wc(20);
		`CHK(tdem, 32'sh61a8);
		wr(OFS_CTRL, 32'h13);
		rc(OFS_CTRL, 32'h1);
		rc(OFS_SPD_LIM, 32'h2710);
		test_done;
	end
endmodule // axis_supervision_manual_in_position_flag_tb_top
`default_nettype wire
